// *** scs_pkg.sv ***
// shared constants for the scam status and target id block
package scs_pkg;
  localparam logic [7:0] ADDR_SCAM = 8'h1A;
  localparam logic [7:0] ADDR_MAP_LOW = 8'h1B;
  localparam logic [7:0] ADDR_MAP_HIGH = 8'h1C;
  localparam logic [7:0] ADDR_SELECTED = 8'h20;
  localparam int BIT_SELO = 7;
  localparam int BIT_SELD = 6;
  localparam int BIT_ALT = 5;
  localparam int BIT_DFLT = 4;
  localparam logic [1:0] LVL_OFF = 2'h0;
  localparam logic [1:0] LVL_ONE = 2'h1;
  localparam logic [1:0] LVL_TWO = 2'h2;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] MAP_RST = 8'h00;
  localparam logic [3:0] CAPTURED_RST = 4'h0;
  localparam logic [7:0] RD_RST = 8'h00;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TIMER_HALF_NS = 51200;
  localparam int TIMER_HALF_CYC = TIMER_HALF_NS / CLK_PERIOD_NS;
  localparam int TIMER_CNT_W = 12;
endpackage : scs_pkg

// *** scs_sel_if.sv ***
// selection-in signals between the register top and the id decoder
`timescale 1ns/1ps
`default_nettype none
interface scs_sel_if;
  logic [15:0] map;
  logic sel_req;
  logic [3:0] sel_id;
  logic bus_free;
  logic claim;
  logic [3:0] captured;
  modport top (output map, output sel_req, output sel_id, output bus_free, input claim, input captured);
  modport dec (input map, input sel_req, input sel_id, input bus_free, output claim, output captured);
endinterface : scs_sel_if
`default_nettype wire

// *** scs_timer.sv ***
// free-running slow square-wave timer bit
`timescale 1ns/1ps
`default_nettype none
module scs_timer #(
  parameter int HALF_CYC = scs_pkg::TIMER_HALF_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic chip_rst_i,
  output logic slow_timer_bit_o
);
  typedef struct packed {
    logic [scs_pkg::TIMER_CNT_W-1:0] cnt;
    logic bit_v;
  } scs_tmr_t;

  localparam logic [scs_pkg::TIMER_CNT_W-1:0] LAST = scs_pkg::TIMER_CNT_W'(HALF_CYC - 1);

  scs_tmr_t s_r;
  scs_tmr_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (chip_rst_i) begin
      s_nxt.cnt = '0; // see RULE_13
      s_nxt.bit_v = 1'b1;
    end else if (s_r.cnt == LAST) begin
      s_nxt.cnt = '0;
      s_nxt.bit_v = ~s_r.bit_v; // see RULE_12 see RULE_17
    end else begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  // reads one in reset; first toggle comes one half period after release
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '{cnt: '0, bit_v: 1'b1}; // see RULE_13
    end else begin
      s_r <= s_nxt;
    end
  end

  assign slow_timer_bit_o = s_r.bit_v;
endmodule : scs_timer
`default_nettype wire

// *** scs_iddec.sv ***
// selection-in target map decode and captured id
`timescale 1ns/1ps
`default_nettype none
module scs_iddec (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic chip_rst_i,
  scs_sel_if.dec sel
);
  typedef struct packed {
    logic claim;
    logic [3:0] captured;
  } scs_dec_t;

  scs_dec_t s_r;
  scs_dec_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.claim = 1'b0;
    if (chip_rst_i || sel.bus_free) begin
      s_nxt.captured = scs_pkg::CAPTURED_RST; // see RULE_15
    end else if (sel.sel_req && sel.map[sel.sel_id]) begin
      s_nxt.claim = 1'b1; // see RULE_09
      s_nxt.captured = sel.sel_id; // see RULE_14 see RULE_11
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '{claim: 1'b0, captured: scs_pkg::CAPTURED_RST}; // see RULE_15
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sel.claim = s_r.claim;
  assign sel.captured = s_r.captured;
endmodule : scs_iddec
`default_nettype wire

// *** scs_top.sv ***
// scam status, target id map, captured id and slow timer registers
//
// Contract
// RULE_01 - with scam level zero every bit of the scam status reads zero.
// RULE_02 - status bit 7 mirrors the selection-out enable control bit.
// RULE_03 - selection done (bit 6) sets on a completed scam selection and clears on a later bus free after a clear request.
// RULE_04 - level 1 sets selection done only for own selections, level 2 also for selections by other devices.
// RULE_05 - the scsi interrupt is asserted whenever selection done is set, with no mask.
// RULE_06 - status bit 5 mirrors alternate timeout select and bit 4 the default id flag.
// RULE_07 - status bits 1-0 mirror the scam level and bits 3-2 read zero.
// RULE_08 - software loads the low and high target maps, one bit per id 0-7 and 8-15.
// RULE_09 - the target map is used only to decode incoming selections, never for reselection.
// RULE_10 - software puts the reselection id in the own id field before reselecting as target.
// RULE_11 - after a valid selection-in the responding id reads in the low 4 bits of the selected id register.
// RULE_12 - a free-running timer bit with a 102.40 us period reads as bit 7 of the selected id register.
// RULE_13 - the timer bit is one during chip reset and for 51.2 us after release.
// RULE_14 - the captured id loads from the bus id when the block claims the bus with busy.
// RULE_15 - the captured id clears on pci reset, software chip reset or bus free.
// RULE_16 - scam level 0 disables, 1 gives level 1, 2 adds selection detect and default id, 3 is reserved.
// RULE_17 - the timer bit toggles every 51.2 us half period.
`timescale 1ns/1ps
`default_nettype none
module scs_top #(
  parameter int HALF_CYC = scs_pkg::TIMER_HALF_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic chip_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  input wire logic sel_done_own_i,
  input wire logic sel_done_other_i,
  input wire logic bus_free_i,
  input wire logic sel_req_i,
  input wire logic [3:0] sel_id_i,
  output logic bsy_claim_o,
  output logic scsi_irq_o,
  output logic selection_out_enable_o,
  output logic alternate_timeout_select_o,
  output logic default_id_flag_o,
  output logic [1:0] scam_level_field_o
);
  typedef struct packed {
    logic selo;
    logic alt;
    logic dflt;
    logic [1:0] lvl;
    logic seld;
    logic clr_pend;
    logic [7:0] map_lo;
    logic [7:0] map_hi;
    logic [7:0] rd_data;
  } scs_state_t;

  scs_state_t s_r;
  scs_state_t s_nxt;
  logic timer_bit;
  logic [7:0] status_v;
  logic [1:0] wr_lvl;

  scs_sel_if sel ();

  scs_timer #(
    .HALF_CYC(HALF_CYC)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .chip_rst_i(chip_rst_i),
    .slow_timer_bit_o(timer_bit)
  );

  scs_iddec u_iddec (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .chip_rst_i(chip_rst_i),
    .sel(sel.dec)
  );

  assign sel.map = {s_r.map_hi, s_r.map_lo}; // see RULE_08
  assign sel.sel_req = sel_req_i;
  assign sel.sel_id = sel_id_i;
  assign sel.bus_free = bus_free_i;
  assign wr_lvl = wr_data_i[1:0];

  always_comb begin
    status_v = 8'h00;
    if (s_r.lvl != scs_pkg::LVL_OFF) begin // see RULE_01
      status_v[scs_pkg::BIT_SELO] = s_r.selo; // see RULE_02
      status_v[scs_pkg::BIT_SELD] = s_r.seld; // see RULE_03
      status_v[scs_pkg::BIT_ALT] = s_r.alt; // see RULE_06
      status_v[scs_pkg::BIT_DFLT] = s_r.dflt; // see RULE_06
      status_v[1:0] = s_r.lvl; // see RULE_07
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rd_data = scs_pkg::RD_RST;
    if (wr_i) begin
      unique case (addr_i)
        scs_pkg::ADDR_SCAM: begin
          s_nxt.lvl = wr_lvl; // see RULE_16
          // upper control bits are held clear while scam is off
          s_nxt.selo = (wr_lvl != scs_pkg::LVL_OFF) && wr_data_i[scs_pkg::BIT_SELO];
          s_nxt.alt = (wr_lvl != scs_pkg::LVL_OFF) && wr_data_i[scs_pkg::BIT_ALT];
          // default id only exists at level 2
          s_nxt.dflt = (wr_lvl == scs_pkg::LVL_TWO) && wr_data_i[scs_pkg::BIT_DFLT]; // see RULE_16
          if (wr_data_i[scs_pkg::BIT_SELD]) begin
            s_nxt.clr_pend = 1'b1; // see RULE_03
          end
        end
        scs_pkg::ADDR_MAP_LOW: s_nxt.map_lo = wr_data_i; // see RULE_08
        scs_pkg::ADDR_MAP_HIGH: s_nxt.map_hi = wr_data_i; // see RULE_08
        default: ;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        scs_pkg::ADDR_SCAM: s_nxt.rd_data = status_v;
        scs_pkg::ADDR_MAP_LOW: s_nxt.rd_data = s_r.map_lo;
        scs_pkg::ADDR_MAP_HIGH: s_nxt.rd_data = s_r.map_hi;
        scs_pkg::ADDR_SELECTED: s_nxt.rd_data = {timer_bit, 3'h0, sel.captured}; // see RULE_11 see RULE_12
        default: s_nxt.rd_data = scs_pkg::RD_RST;
      endcase
    end
    // a pending clear is consumed by the next bus free
    if (bus_free_i && s_r.clr_pend) begin
      s_nxt.seld = 1'b0; // see RULE_03
      s_nxt.clr_pend = 1'b0;
    end
    // set after clear so a completion in the same cycle is not lost
    if ((s_r.lvl == scs_pkg::LVL_ONE || s_r.lvl == scs_pkg::LVL_TWO) && sel_done_own_i) begin
      s_nxt.seld = 1'b1; // see RULE_04
    end
    if (s_r.lvl == scs_pkg::LVL_TWO && sel_done_other_i) begin
      s_nxt.seld = 1'b1; // see RULE_04
    end
    if (chip_rst_i) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_data_o = s_r.rd_data;
  assign scsi_irq_o = s_r.seld; // see RULE_05
  assign bsy_claim_o = sel.claim; // see RULE_14
  assign selection_out_enable_o = s_r.selo;
  assign alternate_timeout_select_o = s_r.alt;
  assign default_id_flag_o = s_r.dflt;
  assign scam_level_field_o = s_r.lvl;
endmodule : scs_top
`default_nettype wire

// *** scs_asserts.sv ***
// property checker for the scam status and target id block
`timescale 1ns/1ps
`default_nettype none
module scs_chk (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic chip_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rd_data_o,
  input wire logic sel_done_own_i,
  input wire logic sel_done_other_i,
  input wire logic bus_free_i,
  input wire logic sel_req_i,
  input wire logic bsy_claim_o,
  input wire logic scsi_irq_o,
  input wire logic selection_out_enable_o,
  input wire logic [1:0] scam_level_field_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i || chip_rst_i);
  wire logic st = rd_i && addr_i == scs_pkg::ADDR_SCAM;
  wire logic ctl = wr_i && addr_i == scs_pkg::ADDR_SCAM;
  wire logic [1:0] lv = scam_level_field_o;
  // writes are excluded: a level change in the same edge makes the outcome ambiguous
  sequence s_own; sel_done_own_i && !wr_i && lv inside {2'h1, 2'h2}; endsequence
  property p_set; s_own |=> scsi_irq_o; endproperty
  a_set: assert property (p_set) else $error("done not raised");
  property p_l1; sel_done_other_i && !sel_done_own_i && !scsi_irq_o && lv == 2'h1 && !wr_i |=> !scsi_irq_o; endproperty
  a_l1: assert property (p_l1) else $error("foreign done at level 1");
  property p_hold; scsi_irq_o && !bus_free_i && !wr_i |=> scsi_irq_o; endproperty
  a_hold: assert property (p_hold) else $error("done lost while busy");
  property p_off; st && lv == scs_pkg::LVL_OFF |=> rd_data_o == 8'h00; endproperty
  a_off: assert property (p_off) else $error("status not zero");
  property p_bits; st && lv != 2'h0 |=> rd_data_o[7] == $past(selection_out_enable_o) && rd_data_o[6] == $past(scsi_irq_o)
    && rd_data_o[3:2] == 2'h0 && rd_data_o[1:0] == $past(lv); endproperty
  a_bits: assert property (p_bits) else $error("status bits wrong");
  property p_lvl; ctl |=> lv == $past(wr_data_i[1:0]); endproperty
  a_lvl: assert property (p_lvl) else $error("level mirror wrong");
  property p_selo; ctl |=> selection_out_enable_o == $past(wr_data_i[7] && wr_data_i[1:0] != 2'h0); endproperty
  a_selo: assert property (p_selo) else $error("sel-out mirror wrong");
  property p_claim; bsy_claim_o |-> $past(sel_req_i) && !$past(bus_free_i) ##1 !bsy_claim_o; endproperty
  a_claim: assert property (p_claim) else $error("bad claim");
endmodule : scs_chk
`default_nettype wire

// *** scs_bus_model.sv ***
// far-side scsi bus model: bus free level and selection-in requests
`timescale 1ns/1ps
`default_nettype none
module scs_bus_model (
  input wire logic clk_i,
  input wire logic bsy_claim_i,
  output logic bus_free_o,
  output logic sel_req_o,
  output logic [3:0] sel_id_o
);
  initial begin
    bus_free_o = 1'h1;
    sel_req_o = 1'h0;
    sel_id_o = 4'h0;
  end
  // only selection-in is modelled; a reselection id goes through the own id field, never the map
  // slow keeps the bus busy a while before the request
  task automatic select(input logic [3:0] id, input int slow, output logic claimed);
    @(posedge clk_i);
    bus_free_o <= 1'h0;
    repeat (slow + 1) @(posedge clk_i);
    sel_req_o <= 1'h1;
    sel_id_o <= id;
    @(posedge clk_i);
    sel_req_o <= 1'h0;
    sel_id_o <= ~id; // lines drift once the request is gone
    #1 claimed = bsy_claim_i;
  endtask : select
  task automatic idle();
    @(posedge clk_i);
    bus_free_o <= 1'h1;
    @(posedge clk_i);
  endtask : idle
endmodule : scs_bus_model
`default_nettype wire

// *** scs_top_tb.sv ***
// self-checking bench for the scam status and target id block
`timescale 1ns/1ps
`default_nettype none
`define chk(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module scs_top_tb;
  logic sys_clk_i = 1'h0, rst_i = 1'h1, chip_rst_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0, own = 1'h0, od = 1'h0;
  logic bf, sr, clm, irq, c;
  logic so, alt, dfl;
  logic [1:0] lvo;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdat;
  logic [3:0] sid;
  logic [15:0] map = 16'h0388;
  int fails = 0, n_checks = 0, cyc = 0;
  initial begin forever #10 sys_clk_i = ~sys_clk_i; end
  scs_top #(.HALF_CYC(8)) DUT (.sys_clk_i, .rst_i, .chip_rst_i, .addr_i(addr), .wr_data_i(wdat), .wr_i, .rd_i,
    .rd_data_o(rdat), .sel_done_own_i(own), .sel_done_other_i(od), .bus_free_i(bf), .sel_req_i(sr), .sel_id_i(sid),
    .bsy_claim_o(clm), .scsi_irq_o(irq), .selection_out_enable_o(so), .alternate_timeout_select_o(alt),
    .default_id_flag_o(dfl), .scam_level_field_o(lvo));
  scs_bus_model m (.clk_i(sys_clk_i), .bsy_claim_i(clm), .bus_free_o(bf), .sel_req_o(sr), .sel_id_o(sid));
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk_i);
    wr_i <= 1'h1;
    addr <= a;
    wdat <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e, k);
    @(posedge sys_clk_i);
    rd_i <= 1'h1;
    addr <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'h0;
    #1 `chk(rdat & k, e)
  endtask : rd
  task automatic ev(input logic o, e);
    @(posedge sys_clk_i);
    own <= o;
    od <= !o;
    @(posedge sys_clk_i);
    own <= 1'h0;
    od <= 1'h0;
    #1 `chk(irq, e)
  endtask : ev
  task automatic complete_run();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    rd(scs_pkg::ADDR_SCAM, 8'h00, 8'hFF);
    @(posedge sys_clk_i);
    chip_rst_i <= 1'h1;
    @(posedge sys_clk_i);
    chip_rst_i <= 1'h0;
    rd(scs_pkg::ADDR_SELECTED, 8'h80, 8'hFF);
    repeat (2) @(posedge sys_clk_i);
    for (int i = 0; i < 4; i++) begin
      repeat (6) @(posedge sys_clk_i);
      rd(scs_pkg::ADDR_SELECTED, {i[0], 7'h00}, 8'h80);
    end
    $display("timer test done");
    for (int l = 0; l < 4; l++) begin
      wr(scs_pkg::ADDR_SCAM, {6'h2C, l[1:0]});
      rd(scs_pkg::ADDR_SCAM, l == 0 ? 8'h00 : {3'h5, l == 2, 2'h0, l[1:0]}, 8'hFF);
      `chk({so, alt, dfl, lvo}, l == 0 ? 5'h00 : {2'h3, l == 2, l[1:0]})
    end
    // level 3 is reserved: neither kind of completion may raise done
    ev(1'h1, 1'h0);
    ev(1'h0, 1'h0);
    $display("mirror test done");
    wr(scs_pkg::ADDR_MAP_LOW, map[7:0]);
    wr(scs_pkg::ADDR_MAP_HIGH, map[15:8]);
    rd(scs_pkg::ADDR_MAP_HIGH, map[15:8], 8'hFF);
    rd(8'h55, 8'h00, 8'hFF);
    for (int i = 0; i < 16; i++) begin
      m.select(i[3:0], i % 3, c);
      `chk(c, map[i])
      rd(scs_pkg::ADDR_SELECTED, map[i] ? i[7:0] : 8'h00, 8'h7F);
      m.idle();
      rd(scs_pkg::ADDR_SELECTED, 8'h00, 8'h7F);
    end
    $display("select test done");
    wr(scs_pkg::ADDR_SCAM, 8'h01);
    ev(1'h0, 1'h0);
    ev(1'h1, 1'h1);
    m.select(4'h3, 0, c);
    `chk(c, 1'h1)
    // clear requested while the bus is busy must wait for bus free
    wr(scs_pkg::ADDR_SCAM, 8'h41);
    rd(scs_pkg::ADDR_SCAM, 8'h41, 8'hFF);
    m.idle();
    rd(scs_pkg::ADDR_SCAM, 8'h01, 8'hFF);
    wr(scs_pkg::ADDR_SCAM, 8'h02);
    ev(1'h0, 1'h1);
    wr(scs_pkg::ADDR_SCAM, 8'h42);
    wr(scs_pkg::ADDR_SCAM, 8'h00);
    ev(1'h1, 1'h0);
    $display("done test done");
    complete_run();
  end
endmodule : scs_top_tb
bind scs_top scs_chk u_chk (.*);
`default_nettype wire
